// file: src/sed_pkg.sv
// shared constants and types for the stream entry stage-1 config decoder
`default_nettype none
package sed_pkg;
  localparam int ADDR_W = 52;
  localparam int SSID_W = 20;
  localparam int CDMAX_W = 5;
  localparam int CD_SHIFT = 6;
  localparam int CD_L1_DESCRIPTOR_SHIFT = 3;
  // register byte offsets
  localparam logic [4:0] OFS_ENTRY = 5'h00;
  localparam logic [4:0] OFS_PTR_LO = 5'h04;
  localparam logic [4:0] OFS_PTR_HI = 5'h08;
  localparam logic [4:0] OFS_FEATURE = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  // entry register fields
  localparam int F_CONFIG = 0;
  localparam int F_FORMAT = 4;
  localparam int F_CDMAX = 8;
  localparam int F_SECURE = 16;
  localparam int F_STAGE2_AARCH64_FORMAT = 17;
  localparam int F_DSS = 20;
  // feature register fields
  localparam int F_S1P = 0;
  localparam int F_S2P = 1;
  localparam int F_SECURE_STAGE2_SUPPORT = 2;
  localparam int F_TWO_LEVEL_CD_SUPPORT = 3;
  localparam int F_TRANSLATED_CHECK_ENABLE = 4;
  localparam int F_SSIDW = 8;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  localparam logic [31:0] FEATURE_RESET = 32'h0000_0000;
  // stream configuration codes
  localparam logic [2:0] CFG_ABORT = 3'h0;
  localparam logic [2:0] CFG_BYPASS = 3'h4;
  localparam logic [1:0] FMT_LINEAR = 2'h0;
  localparam logic [1:0] FMT_4K = 2'h1;
  localparam logic [1:0] FMT_64K = 2'h2;
  localparam logic [1:0] DSS_BYPASS = 2'h1;
  localparam logic [1:0] DSS_SUB0 = 2'h2;
  localparam logic [6:0] L2_4K_IDX_W = 7'h06;
  localparam logic [6:0] L2_64K_IDX_W = 7'h0A;
  localparam logic [4:0] L1_4K_ALIGN_MIN = 5'h09;
  localparam logic [4:0] L1_64K_ALIGN_MIN = 5'h0D;
  localparam logic [6:0] L1_4K_MASK_OFS = 7'h03;
  localparam logic [6:0] L1_64K_MASK_OFS = 7'h07;
  localparam logic [6:0] L2_4K_ZERO_W = 7'h0C;
  localparam logic [6:0] L2_64K_ZERO_W = 7'h10;
  typedef enum logic [1:0] {KIND_NORMAL = 2'h0, KIND_ATS_REQ = 2'h1, KIND_ATS_XLATED = 2'h2}
    sed_kind_t;
  typedef enum logic [1:0] {RESP_OK = 2'h0, RESP_ABORT = 2'h1, RESP_UR = 2'h2, RESP_CA = 2'h3}
    sed_resp_t;
  typedef enum logic [2:0] {EV_NONE = 3'h0, EV_INVALID_ENTRY = 3'h1, EV_BAD_SUBSTREAM = 3'h2,
    EV_BAD_ATS_TREQ = 3'h3, EV_TRANSL_FORBIDDEN = 3'h4, EV_STREAM_DISABLED = 3'h5} sed_event_t;
endpackage
`default_nettype wire

// file: src/sed_decode.sv
// stream entry stage-1 configuration decoder with avalon-mm register slave
// Operation
// - config 000 blocks traffic, abort, no event
// - reserved configs behave as 000
// - bit0 stage1, bit1 stage2, 100/101/110/111 decoded
// - no stage1: config 1x1 illegal
// - no stage2: config 11x illegal
// - secure entry without secure stage2: 11x illegal
// - secure 11x needs stage2 aarch64 format
// - bypass denies ats requests and translated traffic
// - config 000: ats ur, translated abort silently
// - substreams off: pointer names one descriptor
// - linear table indexed, aligned to size
// - 4k leaf tables of 64 descriptors
// - 4k format: base low bits zeroed above 9
// - 64k leaf tables of 1024 descriptors
// - 64k format: base low bits zeroed above 13
// - stage1 off: substream transactions aborted
// - no two-level support: non-linear format illegal
// - pointer bits 51:6, ipa when stage2
// - substream width zero: substream transactions aborted
// - count zero: substream transactions aborted
// - out-of-range substream aborted with event
// - count above substream width is illegal
// - illegal entry handled as invalid entry
// - invalid entry aborts with invalid entry event
// - default substream mode handles missing substream
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
module sed_decode #(
  parameter int SSID_WIDTH_MAX = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_has_ssid,
  input wire logic [sed_pkg::SSID_W-1:0] req_ssid,
  input wire logic [sed_pkg::ADDR_W-1:0] req_level2_pointer,
  output logic res_valid,
  output logic [1:0] res_resp,
  output logic [2:0] res_event,
  output logic [sed_pkg::ADDR_W-1:0] res_cd_addr,
  output logic [sed_pkg::ADDR_W-1:0] res_l1_addr,
  output logic res_l1_used,
  output logic res_stage1,
  output logic res_stage2,
  output logic res_ptr_is_ipa
);
  if (SSID_WIDTH_MAX < 1 || SSID_WIDTH_MAX > sed_pkg::SSID_W) begin : g_bad_param
    $error("SSID_WIDTH_MAX out of range");
  end

  logic [31:0] entry_reg;
  logic [31:0] ptr_lo_reg;
  logic [31:0] ptr_hi_reg;
  logic [31:0] feature_reg;
  logic [15:0] count_reg;
  logic illegal;
  logic entry_blocks;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [sed_pkg::ADDR_W-1:0] low_mask(input logic [6:0] n);
    logic [sed_pkg::ADDR_W-1:0] ones;
    ones = '1;
    return ~(ones << n);
  endfunction

  // bus slave: one wait cycle, then the access completes at the edge that sees waitrequest low
  wire bus_req = avs_read || avs_write;
  wire bus_done = bus_req && !avs_waitrequest;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && avs_waitrequest) begin
      unique case (avs_address[4:2])
        sed_pkg::OFS_ENTRY[4:2]: avs_readdata <= entry_reg;
        sed_pkg::OFS_PTR_LO[4:2]: avs_readdata <= ptr_lo_reg;
        sed_pkg::OFS_PTR_HI[4:2]: avs_readdata <= ptr_hi_reg;
        sed_pkg::OFS_FEATURE[4:2]: avs_readdata <= feature_reg;
        sed_pkg::OFS_STATUS[4:2]: avs_readdata <= {count_reg, 8'h00, entry_blocks, illegal,
                                                   1'b0, res_event, res_resp};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // writes land only at the completing edge; unmapped offsets drop the data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_reg <= sed_pkg::ENTRY_RESET;
      ptr_lo_reg <= 32'h0000_0000;
      ptr_hi_reg <= 32'h0000_0000;
      feature_reg <= sed_pkg::FEATURE_RESET;
    end else if (ce && bus_done && avs_write) begin
      unique case (avs_address[4:2])
        sed_pkg::OFS_ENTRY[4:2]: entry_reg <= be_merge(entry_reg, avs_writedata, avs_byteenable);
        sed_pkg::OFS_PTR_LO[4:2]: ptr_lo_reg <= be_merge(ptr_lo_reg, avs_writedata,
                                                         avs_byteenable) & 32'hFFFF_FFC0;
        sed_pkg::OFS_PTR_HI[4:2]: ptr_hi_reg <= be_merge(ptr_hi_reg, avs_writedata,
                                                         avs_byteenable) & 32'h000F_FFFF;
        sed_pkg::OFS_FEATURE[4:2]: feature_reg <= be_merge(feature_reg, avs_writedata,
                                                           avs_byteenable);
        default: ;
      endcase
    end
  end

  // entry and feature fields
  wire [2:0] cfg = entry_reg[sed_pkg::F_CONFIG +: 3];
  wire [1:0] fmt = entry_reg[sed_pkg::F_FORMAT +: 2];
  wire [4:0] cdmax = entry_reg[sed_pkg::F_CDMAX +: sed_pkg::CDMAX_W];
  wire secure = entry_reg[sed_pkg::F_SECURE];
  wire stage2_aarch64_format = entry_reg[sed_pkg::F_STAGE2_AARCH64_FORMAT];
  wire [1:0] dss = entry_reg[sed_pkg::F_DSS +: 2];
  wire s1p = feature_reg[sed_pkg::F_S1P];
  wire s2p = feature_reg[sed_pkg::F_S2P];
  wire secure_stage2_support = feature_reg[sed_pkg::F_SECURE_STAGE2_SUPPORT];
  wire two_level_cd_support = feature_reg[sed_pkg::F_TWO_LEVEL_CD_SUPPORT];
  wire translated_check_enable = feature_reg[sed_pkg::F_TRANSLATED_CHECK_ENABLE];
  wire [4:0] ssidw_raw = feature_reg[sed_pkg::F_SSIDW +: sed_pkg::CDMAX_W];
  // capped so software cannot claim more substream bits than the decoder serves
  wire [4:0] ssidw = (ssidw_raw > 5'(SSID_WIDTH_MAX)) ? 5'(SSID_WIDTH_MAX) : ssidw_raw;

  assign entry_blocks = !cfg[2];
  wire st1 = cfg[2] && cfg[0];
  wire st2 = cfg[2] && cfg[1];
  wire is_bypass = (cfg == sed_pkg::CFG_BYPASS);
  wire sub_on = st1 && (ssidw != 5'h00) && (cdmax != 5'h00);
  wire s2_pat = cfg[2] && cfg[1];

  always_comb begin
    illegal = 1'b0;
    if (!s1p && cfg[2] && cfg[0]) illegal = 1'b1;
    if (!s2p && s2_pat) illegal = 1'b1;
    if (secure && s2p && !secure_stage2_support && s2_pat) illegal = 1'b1;
    if (secure && s2_pat && !stage2_aarch64_format) illegal = 1'b1;
    if (st1 && ssidw != 5'h00 && cdmax > ssidw) illegal = 1'b1;
    if (sub_on && !two_level_cd_support && fmt != sed_pkg::FMT_LINEAR) illegal = 1'b1;
    if (entry_blocks) illegal = 1'b0;
  end

  // verdict for the presented request
  logic [1:0] v_resp;
  logic [2:0] v_event;
  logic v_s1;
  logic ssid_out_of_range;

  always_comb begin
    ssid_out_of_range = ((req_ssid >> cdmax) != '0);
    v_resp = sed_pkg::RESP_OK;
    v_event = sed_pkg::EV_NONE;
    v_s1 = st1;
    if (entry_blocks) begin
      if (req_kind == sed_pkg::KIND_ATS_REQ) begin
        v_resp = sed_pkg::RESP_UR;
      end else if (req_kind == sed_pkg::KIND_NORMAL || translated_check_enable) begin
        v_resp = sed_pkg::RESP_ABORT;
      end
    end else if (illegal) begin
      if (req_kind == sed_pkg::KIND_ATS_REQ) begin
        v_resp = sed_pkg::RESP_CA;
      end else if (req_kind == sed_pkg::KIND_NORMAL) begin
        v_resp = sed_pkg::RESP_ABORT;
        v_event = sed_pkg::EV_INVALID_ENTRY;
      end else if (translated_check_enable) begin
        v_resp = sed_pkg::RESP_ABORT;
      end
    end else if (is_bypass && req_kind == sed_pkg::KIND_ATS_REQ) begin
      v_resp = sed_pkg::RESP_UR;
      v_event = sed_pkg::EV_BAD_ATS_TREQ;
    end else if (is_bypass && req_kind == sed_pkg::KIND_ATS_XLATED && translated_check_enable) begin
      v_resp = sed_pkg::RESP_ABORT;
      v_event = sed_pkg::EV_TRANSL_FORBIDDEN;
    end else if (req_kind != sed_pkg::KIND_ATS_XLATED) begin
      if (req_has_ssid) begin
        if (!st1 || ssidw == 5'h00 || cdmax == 5'h00 || ssid_out_of_range) begin
          v_resp = sed_pkg::RESP_ABORT;
          v_event = sed_pkg::EV_BAD_SUBSTREAM;
        end else if (dss == sed_pkg::DSS_SUB0 && req_ssid == '0) begin
          v_resp = sed_pkg::RESP_ABORT;
          v_event = sed_pkg::EV_STREAM_DISABLED;
        end
      end else if (sub_on) begin
        if (dss == sed_pkg::DSS_BYPASS) begin
          v_s1 = 1'b0;
        end else if (dss != sed_pkg::DSS_SUB0) begin
          v_resp = sed_pkg::RESP_ABORT;
          v_event = sed_pkg::EV_STREAM_DISABLED;
        end
      end
      // translation requests refused for a disabled stream complete with ca and stay silent
      if (req_kind == sed_pkg::KIND_ATS_REQ && v_event == sed_pkg::EV_STREAM_DISABLED) begin
        v_resp = sed_pkg::RESP_CA;
        v_event = sed_pkg::EV_NONE;
      end
    end
  end

  // descriptor address
  wire [sed_pkg::ADDR_W-1:0] base = {ptr_hi_reg[19:0], ptr_lo_reg};
  wire [sed_pkg::ADDR_W-1:0] idx = {32'h0000_0000, (req_has_ssid ? req_ssid : '0)};
  logic [sed_pkg::ADDR_W-1:0] a_cd;
  logic [sed_pkg::ADDR_W-1:0] a_l1;
  logic a_l1_used;

  always_comb begin
    a_cd = base;
    a_l1 = '0;
    a_l1_used = 1'b0;
    if (sub_on && fmt == sed_pkg::FMT_4K) begin
      a_l1_used = 1'b1;
      a_l1 = base & ~low_mask((cdmax > sed_pkg::L1_4K_ALIGN_MIN) ?
               ({2'h0, cdmax} - sed_pkg::L1_4K_MASK_OFS) : 7'(sed_pkg::CD_SHIFT));
      if (cdmax > 5'(sed_pkg::L2_4K_IDX_W)) begin
        a_l1 = a_l1 | ((idx >> sed_pkg::L2_4K_IDX_W) << sed_pkg::CD_L1_DESCRIPTOR_SHIFT);
      end
      a_cd = (req_level2_pointer & ~low_mask(sed_pkg::L2_4K_ZERO_W))
             | ((idx & low_mask(sed_pkg::L2_4K_IDX_W)) << sed_pkg::CD_SHIFT);
    end else if (sub_on && fmt == sed_pkg::FMT_64K) begin
      a_l1_used = 1'b1;
      a_l1 = base & ~low_mask((cdmax > sed_pkg::L1_64K_ALIGN_MIN) ?
               ({2'h0, cdmax} - sed_pkg::L1_64K_MASK_OFS) : 7'(sed_pkg::CD_SHIFT));
      if (cdmax > 5'(sed_pkg::L2_64K_IDX_W)) begin
        a_l1 = a_l1 | ((idx >> sed_pkg::L2_64K_IDX_W) << sed_pkg::CD_L1_DESCRIPTOR_SHIFT);
      end
      a_cd = (req_level2_pointer & ~low_mask(sed_pkg::L2_64K_ZERO_W))
             | ((idx & low_mask(sed_pkg::L2_64K_IDX_W)) << sed_pkg::CD_SHIFT);
    end else if (sub_on) begin
      // linear and reserved format share one layout
      a_cd = (base & ~low_mask({2'h0, cdmax} + 7'(sed_pkg::CD_SHIFT)))
             | ((idx & low_mask({2'h0, cdmax})) << sed_pkg::CD_SHIFT);
    end
  end

  // registered answer, one per request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_valid <= 1'b0;
    end else if (ce) begin
      res_valid <= req_valid;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_resp <= sed_pkg::RESP_OK;
      res_event <= sed_pkg::EV_NONE;
      res_cd_addr <= '0;
      res_l1_addr <= '0;
      res_l1_used <= 1'b0;
      res_stage1 <= 1'b0;
      res_stage2 <= 1'b0;
      res_ptr_is_ipa <= 1'b0;
    end else if (ce && req_valid) begin
      res_resp <= v_resp;
      res_event <= v_event;
      res_cd_addr <= a_cd;
      res_l1_addr <= a_l1;
      res_l1_used <= a_l1_used && v_s1;
      res_stage1 <= v_s1 && (v_resp == sed_pkg::RESP_OK);
      res_stage2 <= st2 && (v_resp == sed_pkg::RESP_OK);
      res_ptr_is_ipa <= st2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 16'h0000;
    end else if (ce && req_valid) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_block_abort_silent: assert property ((ce && req_valid && entry_blocks &&
      req_kind == sed_pkg::KIND_NORMAL) |=> (res_valid && res_resp == sed_pkg::RESP_ABORT &&
      res_event == sed_pkg::EV_NONE)) else $error("blocked stream not aborted silently");
  chk_reserved_as_block: assert property ((ce && req_valid && !cfg[2] && cfg != 3'h0 &&
      (req_kind != sed_pkg::KIND_ATS_XLATED || translated_check_enable)) |=>
      (res_stage1 == 1'b0 && res_stage2 == 1'b0 && res_resp != sed_pkg::RESP_OK))
      else $error("reserved config let traffic pass");
  chk_block_ats_ur: assert property ((ce && req_valid && entry_blocks &&
      req_kind == sed_pkg::KIND_ATS_REQ) |=> (res_resp == sed_pkg::RESP_UR &&
      res_event == sed_pkg::EV_NONE)) else $error("ats request on blocked stream not ur");
  chk_bypass_treq: assert property ((ce && req_valid && is_bypass && !illegal &&
      req_kind == sed_pkg::KIND_ATS_REQ) |=> (res_event == sed_pkg::EV_BAD_ATS_TREQ))
      else $error("bypass ats request not denied");
  chk_illegal_event: assert property ((ce && req_valid && illegal &&
      req_kind == sed_pkg::KIND_NORMAL) |=> (res_event == sed_pkg::EV_INVALID_ENTRY &&
      res_resp == sed_pkg::RESP_ABORT)) else $error("illegal entry not treated as invalid");
  chk_no_s1_illegal: assert property ((!s1p && cfg == 3'h5) |-> illegal)
      else $error("stage1 config accepted without stage1");
  chk_no_s2_illegal: assert property ((!s2p && cfg == 3'h6) |-> illegal)
      else $error("stage2 config accepted without stage2");
  chk_substream_range: assert property ((ce && req_valid && !illegal && cfg == 3'h5 &&
      req_kind == sed_pkg::KIND_NORMAL && req_has_ssid && ssid_out_of_range) |=>
      (res_event == sed_pkg::EV_BAD_SUBSTREAM)) else $error("ssid out of range passed");
  chk_s1_off_ssid: assert property ((ce && req_valid && cfg == 3'h6 && !illegal &&
      req_kind == sed_pkg::KIND_NORMAL && req_has_ssid) |=>
      (res_resp == sed_pkg::RESP_ABORT && res_event == sed_pkg::EV_BAD_SUBSTREAM))
      else $error("ssid accepted with stage1 off");
  chk_one_cd: assert property ((ce && req_valid && !sub_on) |=>
      (res_cd_addr == $past(base) && !res_l1_used)) else $error("single cd address wrong");
  chk_dss_bypass: assert property ((ce && req_valid && sub_on && !illegal && !req_has_ssid &&
      req_kind == sed_pkg::KIND_NORMAL && dss == sed_pkg::DSS_BYPASS) |=>
      (res_resp == sed_pkg::RESP_OK && !res_stage1)) else $error("stage1 not bypassed");
  chk_bus_two_cycles: assert property ((ce && bus_req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer late");
endmodule
`default_nettype wire

// file: verif/sed_client.sv
// client device model issuing lookups and catching the result pulse
`default_nettype none
module sed_client (
  input wire logic clk,
  output logic req_valid,
  output logic [1:0] req_kind,
  output logic req_has_ssid,
  output logic [sed_pkg::SSID_W-1:0] req_ssid,
  output logic [sed_pkg::ADDR_W-1:0] req_level2_pointer,
  input wire logic res_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'b0;
    req_kind = 2'h0;
    req_has_ssid = 1'b0;
    req_ssid = '0;
    req_level2_pointer = '0;
  end
  task automatic issue(input logic [1:0] k, input logic h, input logic [19:0] s,
                       input logic [51:0] p, output logic seen);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_has_ssid <= h;
    req_ssid <= s;
    req_level2_pointer <= p;
    @(posedge clk);
    req_valid <= 1'b0;
    // released ssid, pointer and kind lines flip so a stale value is never mistaken for a live one
    req_ssid <= ~s;
    req_level2_pointer <= ~p;
    req_kind <= ~k;
    @(negedge clk);
    seen = res_valid;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_stream_entry_stage1_config_decode.sv
// self-checking bench for the stage-1 config decoder
`default_nettype none
module tb_stream_entry_stage1_config_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, req_valid, req_has_ssid, res_valid, res_l1_used;
  logic res_stage1, res_stage2, res_ptr_is_ipa, seen;
  logic [1:0] req_kind, res_resp;
  logic [2:0] res_event;
  logic [19:0] req_ssid;
  logic [51:0] req_level2_pointer, res_cd_addr, res_l1_addr;
  logic [51:0] l2 = 52'h1_2345_6780_0FFF;
  // pointer as written has low bits set; the decoder must drop bits 5:0
  localparam logic [51:0] P = 52'h9_8765_4321_0FC0;
  int miscompares = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  sed_decode u_sed_decode (.clk(clk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .req_valid(req_valid), .req_kind(req_kind), .req_has_ssid(req_has_ssid),
    .req_ssid(req_ssid), .req_level2_pointer(req_level2_pointer), .res_valid(res_valid),
    .res_resp(res_resp), .res_event(res_event), .res_cd_addr(res_cd_addr),
    .res_l1_addr(res_l1_addr), .res_l1_used(res_l1_used), .res_stage1(res_stage1),
    .res_stage2(res_stage2), .res_ptr_is_ipa(res_ptr_is_ipa));
  sed_client u_sed_client (.clk(clk), .req_valid(req_valid), .req_kind(req_kind),
    .req_has_ssid(req_has_ssid), .req_ssid(req_ssid),
    .req_level2_pointer(req_level2_pointer), .res_valid(res_valid));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 20);
    q = avs_readdata;
    chk(avs_waitrequest, 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [31:0] ent(input logic [2:0] c, input logic [1:0] fm,
                                      input logic [4:0] mx, input logic [1:0] sa);
    return {14'h0000, sa, 3'h0, mx, 2'h0, fm, 1'h0, c};
  endfunction
  function automatic logic [31:0] fe(input logic [4:0] b, input logic [4:0] w);
    return {19'h00000, w, 3'h0, b};
  endfunction
  task automatic setup(input logic [31:0] e, input logic [31:0] f);
    bus(1'b1, sed_pkg::OFS_FEATURE, f);
    bus(1'b1, sed_pkg::OFS_ENTRY, e);
  endtask
  task automatic look(input logic [1:0] k, input logic h, input logic [19:0] s,
                      input logic [1:0] r, input logic [2:0] ev);
    u_sed_client.issue(k, h, s, l2, seen);
    chk(seen, 1'b1);
    chk(res_resp, r);
    chk(res_event, ev);
  endtask
  task automatic t_regs();
    bus(1'b0, sed_pkg::OFS_ENTRY, 32'h0000_0000);
    chk(q, sed_pkg::ENTRY_RESET);
    bus(1'b0, sed_pkg::OFS_FEATURE, 32'h0000_0000);
    chk(q, sed_pkg::FEATURE_RESET);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b1, sed_pkg::OFS_PTR_LO, 32'h4321_0FFF);
    bus(1'b1, sed_pkg::OFS_PTR_HI, 32'h0009_8765);
    bus(1'b0, sed_pkg::OFS_PTR_LO, 32'h0000_0000);
    chk(q, 32'h4321_0FC0);
  endtask
  task automatic t_config();
    logic [2:0] c;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      r = c[2] ? sed_pkg::RESP_OK : sed_pkg::RESP_ABORT;
      setup(ent(c, 2'h0, 5'h00, 2'h0), fe(5'h13, 5'h08));
      look(sed_pkg::KIND_NORMAL, 1'b0, 20'h00000, r, sed_pkg::EV_NONE);
      if (c[2]) begin
        chk(res_stage1, c[0]);
        chk(res_stage2, c[1]);
        chk(res_ptr_is_ipa, c[1]);
      end
      if (c[2] && c[0]) chk(res_cd_addr, P);
    end
  endtask
  task automatic illegal(input logic [31:0] e, input logic [31:0] f);
    setup(e, f);
    look(sed_pkg::KIND_NORMAL, 1'b0, 20'h00000, sed_pkg::RESP_ABORT, sed_pkg::EV_INVALID_ENTRY);
    look(sed_pkg::KIND_ATS_REQ, 1'b0, 20'h00000, sed_pkg::RESP_CA, sed_pkg::EV_NONE);
  endtask
  task automatic t_illegal();
    illegal(ent(3'h5, 2'h0, 5'h00, 2'h0), fe(5'h02, 5'h08));
    illegal(ent(3'h6, 2'h0, 5'h00, 2'h0), fe(5'h01, 5'h08));
    illegal(ent(3'h7, 2'h0, 5'h00, 2'h3), fe(5'h03, 5'h08));
    illegal(ent(3'h7, 2'h0, 5'h00, 2'h1), fe(5'h07, 5'h08));
    illegal(ent(3'h5, 2'h1, 5'h04, 2'h0), fe(5'h03, 5'h08));
    illegal(ent(3'h5, 2'h0, 5'h09, 2'h0), fe(5'h0B, 5'h08));
  endtask
  task automatic t_ats();
    setup(ent(3'h4, 2'h0, 5'h00, 2'h0), fe(5'h13, 5'h08));
    look(sed_pkg::KIND_ATS_REQ, 1'b0, 20'h0, sed_pkg::RESP_UR, sed_pkg::EV_BAD_ATS_TREQ);
    look(sed_pkg::KIND_ATS_XLATED, 1'b0, 20'h0, sed_pkg::RESP_ABORT,
         sed_pkg::EV_TRANSL_FORBIDDEN);
    setup(ent(3'h0, 2'h0, 5'h00, 2'h0), fe(5'h13, 5'h08));
    look(sed_pkg::KIND_ATS_REQ, 1'b0, 20'h0, sed_pkg::RESP_UR, sed_pkg::EV_NONE);
    look(sed_pkg::KIND_ATS_XLATED, 1'b0, 20'h0, sed_pkg::RESP_ABORT, sed_pkg::EV_NONE);
    bus(1'b0, sed_pkg::OFS_STATUS, 32'h0000_0000);
    chk(q[15:0], 16'h0081);
    setup(ent(3'h4, 2'h0, 5'h00, 2'h0), fe(5'h03, 5'h08));
    look(sed_pkg::KIND_ATS_XLATED, 1'b0, 20'h0, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
  endtask
  task automatic t_ssid();
    setup(ent(3'h6, 2'h0, 5'h00, 2'h0), fe(5'h0B, 5'h08));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h1, sed_pkg::RESP_ABORT, sed_pkg::EV_BAD_SUBSTREAM);
    setup(ent(3'h5, 2'h0, 5'h00, 2'h0), fe(5'h0B, 5'h08));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h1, sed_pkg::RESP_ABORT, sed_pkg::EV_BAD_SUBSTREAM);
    setup(ent(3'h5, 2'h3, 5'h04, 2'h0), fe(5'h0B, 5'h08));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h10, sed_pkg::RESP_ABORT,
         sed_pkg::EV_BAD_SUBSTREAM);
    look(sed_pkg::KIND_NORMAL, 1'b0, 20'h0, sed_pkg::RESP_ABORT,
         sed_pkg::EV_STREAM_DISABLED);
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h5, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
    chk(res_cd_addr, (P & ~52'h3C0) | 52'h140);
    // count left nonzero: with no substream width it must be ignored, not judged
    setup(ent(3'h5, 2'h0, 5'h04, 2'h0), fe(5'h0B, 5'h00));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h1, sed_pkg::RESP_ABORT, sed_pkg::EV_BAD_SUBSTREAM);
  endtask
  task automatic t_two();
    setup(ent(3'h5, 2'h1, 5'h0C, 2'h0), fe(5'h0B, 5'h14));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h00ABC, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
    chk(res_l1_used, 1'b1);
    chk(res_l1_addr, 52'h9_8765_4321_0F50);
    chk(res_cd_addr, 52'h1_2345_6780_0F00);
    setup(ent(3'h5, 2'h1, 5'h06, 2'h0), fe(5'h0B, 5'h14));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h0002A, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
    chk(res_l1_addr, P);
    chk(res_cd_addr, 52'h1_2345_6780_0A80);
    setup(ent(3'h7, 2'h2, 5'h0E, 2'h0), fe(5'h0B, 5'h14));
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h02ABC, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
    chk(res_l1_addr, 52'h9_8765_4321_0FD0);
    chk(res_cd_addr, 52'h1_2345_6780_AF00);
    chk(res_ptr_is_ipa, 1'b1);
  endtask
  task automatic t_dss();
    logic [31:0] s0;
    setup(ent(3'h5, 2'h0, 5'h04, 2'h0) | 32'h0010_0000, fe(5'h0B, 5'h08));
    look(sed_pkg::KIND_NORMAL, 1'b0, 20'h0, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
    chk(res_stage1, 1'b0);
    setup(ent(3'h5, 2'h0, 5'h04, 2'h0) | 32'h0020_0000, fe(5'h0B, 5'h08));
    look(sed_pkg::KIND_NORMAL, 1'b0, 20'h0, sed_pkg::RESP_OK, sed_pkg::EV_NONE);
    chk(res_stage1, 1'b1);
    chk(res_cd_addr, 52'h9_8765_4321_0C00);
    look(sed_pkg::KIND_NORMAL, 1'b1, 20'h0, sed_pkg::RESP_ABORT,
         sed_pkg::EV_STREAM_DISABLED);
    bus(1'b0, sed_pkg::OFS_STATUS, 32'h0000_0000);
    s0 = q;
    look(sed_pkg::KIND_ATS_REQ, 1'b1, 20'h0, sed_pkg::RESP_CA, sed_pkg::EV_NONE);
    bus(1'b0, sed_pkg::OFS_STATUS, 32'h0000_0000);
    chk(q[15:0], 16'h0003);
    chk(q[31:16], s0[31:16] + 16'h0001);
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_config();
    t_illegal();
    t_ats();
    t_ssid();
    t_two();
    t_dss();
    summarize();
  end
  // whole run needs well under a thousand bus and lookup cycles
  initial begin
    #(50 * 20000);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
